// [sbs_pkg.sv]
// Shared constants and state types for the separate-port burst SRAM access logic
package sbs_pkg;
  // Array geometry, narrow configuration
  localparam int ADDR_W      = 21;       // Shared address bus width
  localparam int WORD_W      = 18;       // One burst word
  localparam int LANE_N      = 2;        // Byte lanes per word
  localparam int LANE_W      = 9;        // Bits per byte lane
  localparam int ARRAY_WORDS = 2097152;  // 2 M words per array
  localparam int BURST_LEN   = 2;        // Words per access
  localparam int FIFO_DEPTH  = 16;       // Read data buffer depth

  // Positions of the sampled pins inside the synchroniser bus
  localparam int PIN_WD_LSB   = 0;
  localparam int PIN_ADDR_LSB = 18;
  localparam int PIN_BLS_LSB  = 39;
  localparam int PIN_WPS      = 41;
  localparam int PIN_RPS      = 42;
  localparam int PIN_DLL      = 43;
  localparam int PIN_CN       = 44;
  localparam int PIN_C        = 45;
  localparam int PIN_KN       = 46;
  localparam int PIN_K        = 47;
  localparam int PIN_W        = 48;

  // Strap sampling waits until the synchroniser holds live pin values
  localparam logic [1:0] STRAP_CNT_CAPTURE = 2'h2;
  localparam logic [1:0] STRAP_CNT_DONE    = 2'h3;

  // Read burst fetch states
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_WORD0 = 3'b010,
    RD_WORD1 = 3'b100
  } sbs_rd_state_type;

  // Write capture states
  typedef enum logic [2:0] {
    WR_IDLE   = 3'b001,
    WR_SECOND = 3'b010,
    WR_COMMIT = 3'b100
  } sbs_wr_state_type;
endpackage

// [sbs_sync_fifo.sv]
// Synchronous valid/ready FIFO built from flip-flops
`timescale 1ns/100ps
module sbs_sync_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store_ff [DEPTH];  // Entry storage
  logic [PTR_W-1:0] wrPtr_ff;          // Next entry to fill
  logic [PTR_W-1:0] rdPtr_ff;          // Oldest entry
  logic [PTR_W:0]   count_ff;          // Entries held
  logic [PTR_W-1:0] nxt_wrPtr;
  logic [PTR_W-1:0] nxt_rdPtr;
  logic [PTR_W:0]   nxt_count;
  logic             doPush;
  logic             doPop;

  // Honest full and empty from the fill count
  assign inReady  = (count_ff != (PTR_W+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = store_ff[rdPtr_ff];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // Pointer and count next values
  always_comb begin
    nxt_wrPtr = doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
    nxt_count = count_ff;
    if (doPush && !doPop) begin
      nxt_count = count_ff + 1'b1;
    end else if (doPop && !doPush) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Entry write, data needs no reset
  always_ff @(posedge clk) begin
    if (doPush) begin
      store_ff[wrPtr_ff] <= inData;
    end
  end
endmodule // sbs_sync_fifo

// [sbs_bank_array.sv]
// Two word arrays with per-lane write and write-to-read forwarding
`timescale 1ns/100ps
module sbs_bank_array (
  input  wire logic                                   clk,
  input  wire logic                                   wrEn,
  input  wire logic [sbs_pkg::ADDR_W-1:0]             wrAddr,
  input  wire logic [sbs_pkg::WORD_W-1:0]             wrWord0,
  input  wire logic [sbs_pkg::WORD_W-1:0]             wrWord1,
  input  wire logic [sbs_pkg::LANE_N-1:0]             wrLane0,
  input  wire logic [sbs_pkg::LANE_N-1:0]             wrLane1,
  input  wire logic [sbs_pkg::ADDR_W-1:0]             rdAddr,
  output logic      [sbs_pkg::WORD_W-1:0]             rdWord0,
  output logic      [sbs_pkg::WORD_W-1:0]             rdWord1
);
  logic sameAddr;  // Commit hits the word being read

  assign sameAddr = wrEn & (wrAddr == rdAddr);

  // One slice per byte lane, each lane with storage of its own
  for (genvar ln = 0; ln < sbs_pkg::LANE_N; ln++) begin : gLane
    localparam int LO = ln * sbs_pkg::LANE_W;
    // Even array holds the first word of each burst, odd array the second
    logic [sbs_pkg::LANE_W-1:0] evenArr_ff [sbs_pkg::ARRAY_WORDS];
    logic [sbs_pkg::LANE_W-1:0] oddArr_ff  [sbs_pkg::ARRAY_WORDS];
    // Deselected lanes keep their stored bits
    always_ff @(posedge clk) begin
      if (wrEn && wrLane0[ln]) begin
        evenArr_ff[wrAddr] <= wrWord0[LO +: sbs_pkg::LANE_W];
      end
      if (wrEn && wrLane1[ln]) begin
        oddArr_ff[wrAddr] <= wrWord1[LO +: sbs_pkg::LANE_W];
      end
    end
    // Newest data wins when a commit lands on the word being read
    assign rdWord0[LO +: sbs_pkg::LANE_W] = (sameAddr && wrLane0[ln]) ?
      wrWord0[LO +: sbs_pkg::LANE_W] : evenArr_ff[rdAddr];
    assign rdWord1[LO +: sbs_pkg::LANE_W] = (sameAddr && wrLane1[ln]) ?
      wrWord1[LO +: sbs_pkg::LANE_W] : oddArr_ff[rdAddr];
  end
endmodule // sbs_bank_array

// [sbs_burst_sram.sv]
// Top of the separate-port burst SRAM access logic
// Contract
// - Low disable pin turns internal DLL off
// - Separate write input and read output ports
// - One address bus shared by both ports
// - Each access moves two words per cycle
// - Accesses start only on positive clock rise
// - Write words captured on both input clocks
// - Read words leave on output clock rises
// - Selects and lane selects captured on edges
// - Two 2 M by 18 arrays, one word each
// - Read select low latches read address
// - Read address held in own register
// - First word driven after next clock rise
// - Second word on next output clock rise
// - Outputs float one edge after last word
// - Write select low captures first word
// - Negative clock latches address, second word
// - Both words then committed at address
// - Deselected write port finishes pending write
// - Deselected lanes keep stored contents
// - Both output clocks high at start: single-clock
// - Reads see newest data including forwarding
// - Starts deselected with outputs floating
`timescale 1ns/100ps
module sbs_burst_sram (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic                           kClk,
  input  wire logic                           kClkN,
  input  wire logic                           cClk,
  input  wire logic                           cClkN,
  input  wire logic                           dll_disable_n,
  input  wire logic                           rd_port_sel_n,
  input  wire logic                           wr_port_sel_n,
  input  wire logic [sbs_pkg::LANE_N-1:0]     byte_lane_sel_n,
  input  wire logic [sbs_pkg::ADDR_W-1:0]     addrIn,
  input  wire logic [sbs_pkg::WORD_W-1:0]     wrDataIn,
  output logic      [sbs_pkg::WORD_W-1:0]     rdDataOut,
  output logic                                rdDataOe,
  output logic                                dllEnabled,
  output logic                                singleClkMode
);
  // Reset release chain
  logic rstMeta_ff;
  logic rstSync_ff;
  logic rstN;

  // Release reset through two flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  assign rstN = rstSync_ff;

  // Pin synchroniser and clock edge finder
  logic [sbs_pkg::PIN_W-1:0] pinBus;        // All sampled pins
  logic [sbs_pkg::PIN_W-1:0] sync1_ff;      // First stage, read by stage two only
  logic [sbs_pkg::PIN_W-1:0] sync2_ff;      // Settled pins
  logic [3:0]                clkPrev_ff;    // Last settled K, K#, C, C#
  logic [3:0]                clkNow;        // Settled K, K#, C, C#
  logic                      kRise;
  logic                      kNRise;
  logic                      cRise;
  logic                      cNRise;

  assign pinBus = {kClk, kClkN, cClk, cClkN, dll_disable_n, rd_port_sel_n,
                   wr_port_sel_n, byte_lane_sel_n, addrIn, wrDataIn};
  assign clkNow = {sync2_ff[sbs_pkg::PIN_K], sync2_ff[sbs_pkg::PIN_KN],
                   sync2_ff[sbs_pkg::PIN_C], sync2_ff[sbs_pkg::PIN_CN]};
  assign kRise  = clkNow[3] & ~clkPrev_ff[3];
  assign kNRise = clkNow[2] & ~clkPrev_ff[2];
  assign cRise  = clkNow[1] & ~clkPrev_ff[1];
  assign cNRise = clkNow[0] & ~clkPrev_ff[0];

  // Two flops on every pin, then one more for edges
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      clkPrev_ff <= '0;
    end else begin
      sync1_ff   <= pinBus;
      sync2_ff   <= sync1_ff;
      clkPrev_ff <= clkNow;
    end
  end

  // Settled control and data fields
  logic                       rdSel;     // Read select asserted
  logic                       wrSel;     // Write select asserted
  logic [sbs_pkg::LANE_N-1:0] laneOn;    // Lanes that may be written
  logic [sbs_pkg::ADDR_W-1:0] addrNow;
  logic [sbs_pkg::WORD_W-1:0] dataNow;

  assign rdSel   = ~sync2_ff[sbs_pkg::PIN_RPS];
  assign wrSel   = ~sync2_ff[sbs_pkg::PIN_WPS];
  assign laneOn  = ~sync2_ff[sbs_pkg::PIN_BLS_LSB +: sbs_pkg::LANE_N];
  assign addrNow = sync2_ff[sbs_pkg::PIN_ADDR_LSB +: sbs_pkg::ADDR_W];
  assign dataNow = sync2_ff[sbs_pkg::PIN_WD_LSB +: sbs_pkg::WORD_W];

  // Strap and DLL state
  logic [1:0] strapCnt_ff;    // Wait for live synchroniser contents
  logic       single_ff;      // Input clocks also time the outputs
  logic       dllOn_ff;       // Internal DLL running
  logic [1:0] nxt_strapCnt;
  logic       nxt_single;
  logic       nxt_dllOn;
  logic       ready;          // Strap taken, accesses allowed

  assign ready = (strapCnt_ff == sbs_pkg::STRAP_CNT_DONE);

  // Strap capture once after release, DLL follows its pin
  always_comb begin
    nxt_strapCnt = strapCnt_ff;
    nxt_single   = single_ff;
    if (!ready) begin
      nxt_strapCnt = strapCnt_ff + 2'h1;
    end
    if (strapCnt_ff == sbs_pkg::STRAP_CNT_CAPTURE) begin
      nxt_single = clkNow[1] & clkNow[0];
    end
    nxt_dllOn = sync2_ff[sbs_pkg::PIN_DLL];
  end

  // Strap and DLL registers
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      strapCnt_ff <= '0;
      single_ff   <= 1'b0;
      dllOn_ff    <= 1'b0;
    end else begin
      strapCnt_ff <= nxt_strapCnt;
      single_ff   <= nxt_single;
      dllOn_ff    <= nxt_dllOn;
    end
  end

  // Write capture path
  sbs_pkg::sbs_wr_state_type  wrState_ff;
  sbs_pkg::sbs_wr_state_type  nxt_wrState;
  logic [sbs_pkg::ADDR_W-1:0] wrAddr_ff;     // Write address register
  logic [sbs_pkg::WORD_W-1:0] wrWord0_ff;    // Lower write data register
  logic [sbs_pkg::WORD_W-1:0] wrWord1_ff;    // Upper write data register
  logic [sbs_pkg::LANE_N-1:0] wrLane0_ff;    // Lanes enabled for word 0
  logic [sbs_pkg::LANE_N-1:0] wrLane1_ff;    // Lanes enabled for word 1
  logic [sbs_pkg::ADDR_W-1:0] nxt_wrAddr;
  logic [sbs_pkg::WORD_W-1:0] nxt_wrWord0;
  logic [sbs_pkg::WORD_W-1:0] nxt_wrWord1;
  logic [sbs_pkg::LANE_N-1:0] nxt_wrLane0;
  logic [sbs_pkg::LANE_N-1:0] nxt_wrLane1;
  logic                       memWe;         // Commit pulse to the arrays

  assign memWe = (wrState_ff == sbs_pkg::WR_COMMIT);

  // Write sequence: K rise, K# rise, commit
  always_comb begin
    nxt_wrState = wrState_ff;
    nxt_wrAddr  = wrAddr_ff;
    nxt_wrWord0 = wrWord0_ff;
    nxt_wrWord1 = wrWord1_ff;
    nxt_wrLane0 = wrLane0_ff;
    nxt_wrLane1 = wrLane1_ff;
    case (wrState_ff)
      sbs_pkg::WR_IDLE: begin
        // Start only on K rise with the write port selected
        if (ready && kRise && wrSel) begin
          nxt_wrWord0 = dataNow;
          nxt_wrLane0 = laneOn;
          nxt_wrState = sbs_pkg::WR_SECOND;
        end
      end
      sbs_pkg::WR_SECOND: begin
        // Address and second word on K# rise, select no longer matters
        if (kNRise) begin
          nxt_wrAddr  = addrNow;
          nxt_wrWord1 = dataNow;
          nxt_wrLane1 = laneOn;
          nxt_wrState = sbs_pkg::WR_COMMIT;
        end
      end
      sbs_pkg::WR_COMMIT: begin
        // One-cycle commit of both words
        nxt_wrState = sbs_pkg::WR_IDLE;
      end
      default: begin
        nxt_wrState = sbs_pkg::WR_IDLE;
      end
    endcase
  end

  // Write registers
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wrState_ff <= sbs_pkg::WR_IDLE;
      wrAddr_ff  <= '0;
      wrWord0_ff <= '0;
      wrWord1_ff <= '0;
      wrLane0_ff <= '0;
      wrLane1_ff <= '0;
    end else begin
      wrState_ff <= nxt_wrState;
      wrAddr_ff  <= nxt_wrAddr;
      wrWord0_ff <= nxt_wrWord0;
      wrWord1_ff <= nxt_wrWord1;
      wrLane0_ff <= nxt_wrLane0;
      wrLane1_ff <= nxt_wrLane1;
    end
  end

  // Read request and fetch path
  sbs_pkg::sbs_rd_state_type  rdState_ff;
  sbs_pkg::sbs_rd_state_type  nxt_rdState;
  logic                       rdPend_ff;     // Read waiting for the next K rise
  logic [sbs_pkg::ADDR_W-1:0] rdAddr_ff;     // Read address register
  logic [sbs_pkg::ADDR_W-1:0] fetchAddr_ff;  // Burst being moved to the buffer
  logic                       nxt_rdPend;
  logic [sbs_pkg::ADDR_W-1:0] nxt_rdAddr;
  logic [sbs_pkg::ADDR_W-1:0] nxt_fetchAddr;
  logic [sbs_pkg::WORD_W-1:0] memWord0;
  logic [sbs_pkg::WORD_W-1:0] memWord1;
  logic [sbs_pkg::WORD_W-1:0] fifoInData;
  logic                       fifoInValid;
  logic                       fifoInReady;

  // Pending read, fetch start and word pushes
  always_comb begin
    nxt_rdState   = rdState_ff;
    nxt_rdPend    = rdPend_ff;
    nxt_rdAddr    = rdAddr_ff;
    nxt_fetchAddr = fetchAddr_ff;
    fifoInValid   = 1'b0;
    fifoInData    = memWord0;
    // Next K rise after the request releases the burst
    if (kRise && rdPend_ff && rdState_ff == sbs_pkg::RD_IDLE) begin
      nxt_fetchAddr = rdAddr_ff;
      nxt_rdState   = sbs_pkg::RD_WORD0;
      nxt_rdPend    = 1'b0;
    end
    // New read latches its address on the same K rise
    if (ready && kRise && rdSel) begin
      nxt_rdAddr = addrNow;
      nxt_rdPend = 1'b1;
    end
    case (rdState_ff)
      sbs_pkg::RD_IDLE: begin
        fifoInValid = 1'b0;
      end
      sbs_pkg::RD_WORD0: begin
        // Lower word from the even array, stalls on a full buffer
        fifoInValid = 1'b1;
        fifoInData  = memWord0;
        if (fifoInReady) begin
          nxt_rdState = sbs_pkg::RD_WORD1;
        end
      end
      sbs_pkg::RD_WORD1: begin
        // Upper word from the odd array
        fifoInValid = 1'b1;
        fifoInData  = memWord1;
        if (fifoInReady) begin
          nxt_rdState = sbs_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_rdState = sbs_pkg::RD_IDLE;
      end
    endcase
  end

  // Read registers
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rdState_ff   <= sbs_pkg::RD_IDLE;
      rdPend_ff    <= 1'b0;
      rdAddr_ff    <= '0;
      fetchAddr_ff <= '0;
    end else begin
      rdState_ff   <= nxt_rdState;
      rdPend_ff    <= nxt_rdPend;
      rdAddr_ff    <= nxt_rdAddr;
      fetchAddr_ff <= nxt_fetchAddr;
    end
  end

  // Two arrays, commit forwarded to a same-cycle fetch
  sbs_bank_array uArray (
    .clk     (ref_clk),
    .wrEn    (memWe),
    .wrAddr  (wrAddr_ff),
    .wrWord0 (wrWord0_ff),
    .wrWord1 (wrWord1_ff),
    .wrLane0 (wrLane0_ff),
    .wrLane1 (wrLane1_ff),
    .rdAddr  (fetchAddr_ff),
    .rdWord0 (memWord0),
    .rdWord1 (memWord1)
  );

  // Read data buffer between fetch and output edges
  logic [sbs_pkg::WORD_W-1:0] fifoOutData;
  logic                       fifoOutValid;
  logic                       outEdge;       // Output clock rise, either phase

  sbs_sync_fifo #(
    .WIDTH (sbs_pkg::WORD_W),
    .DEPTH (sbs_pkg::FIFO_DEPTH)
  ) uReadBuf (
    .clk      (ref_clk),
    .rstN     (rstN),
    .inData   (fifoInData),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (outEdge)
  );

  // Output clocks, or input clocks in single-clock mode
  assign outEdge = single_ff ? (kRise | kNRise) : (cRise | cNRise);

  // Output register stage
  logic [sbs_pkg::WORD_W-1:0] rdData_ff;
  logic                       rdOe_ff;
  logic [sbs_pkg::WORD_W-1:0] nxt_rdData;
  logic                       nxt_rdOe;

  // One word per output edge, float when nothing is queued
  always_comb begin
    nxt_rdData = rdData_ff;
    nxt_rdOe   = rdOe_ff;
    if (outEdge) begin
      if (fifoOutValid) begin
        nxt_rdData = fifoOutData;
        nxt_rdOe   = 1'b1;
      end else begin
        nxt_rdOe   = 1'b0;
      end
    end
  end

  // Output registers, floating from reset
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rdData_ff <= '0;
      rdOe_ff   <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdOe_ff   <= nxt_rdOe;
    end
  end

  assign rdDataOut     = rdData_ff;
  assign rdDataOe      = rdOe_ff;
  assign dllEnabled    = dllOn_ff;
  assign singleClkMode = single_ff;
endmodule // sbs_burst_sram

// [sbs_burst_sram_asserts.sv]
// Port checks for the burst SRAM access logic
`timescale 1ns/100ps
module sbs_burst_sram_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        kClk,
  input wire logic        kClkN,
  input wire logic        cClk,
  input wire logic        cClkN,
  input wire logic        dll_disable_n,
  input wire logic        rd_port_sel_n,
  input wire logic [17:0] rdDataOut,
  input wire logic        rdDataOe,
  input wire logic        dllEnabled,
  input wire logic        singleClkMode
);
  logic [2:0] syncA_ff;  // K, output pair, first stage
  logic [2:0] syncB_ff;  // Second stage
  logic [2:0] syncC_ff;  // Previous second stage
  logic [3:0] upCnt_ff;  // Cycles since release, saturating
  logic       rdSeen_ff; // A read was taken since reset
  logic       outEdge;   // Output clock rise seen
  logic       kRise;     // Input clock rise seen
  // Sample clock pins the way the block does
  always_ff @(posedge ref_clk) begin
    syncA_ff <= {kClk, singleClkMode ? {kClk, kClkN} : {cClk, cClkN}};
    syncB_ff <= syncA_ff;
    syncC_ff <= syncB_ff;
  end
  assign outEdge = |(syncB_ff[1:0] & ~syncC_ff[1:0]);
  assign kRise   = syncB_ff[2] & ~syncC_ff[2];
  // Release counter and read history
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_ff  <= 4'h0;
      rdSeen_ff <= 1'b0;
    end else begin
      upCnt_ff  <= (upCnt_ff == 4'hf) ? upCnt_ff : upCnt_ff + 4'h1;
      rdSeen_ff <= rdSeen_ff | (kRise & ~rd_port_sel_n);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_reset_quiet: assert property (
    $rose(rst_b) |-> !rdDataOe && rdDataOut == '0 && !dllEnabled && !singleClkMode)
    else $error("outputs not quiet after reset");
  chk_mode_fixed: assert property (
    upCnt_ff == 4'hf |-> $stable(singleClkMode)) else $error("clock mode changed");
  chk_strap_seen: assert property (
    $rose(singleClkMode) |-> cClk && cClkN) else $error("single mode without strap");
  chk_dll_follow: assert property (
    (upCnt_ff == 4'hf && $stable(dll_disable_n)) [*6] |-> dllEnabled == dll_disable_n)
    else $error("dll status not following pin");
  chk_word_edge: assert property (
    $changed(rdDataOut) |-> $past(outEdge) || $past(outEdge, 2) || $past(outEdge, 3))
    else $error("read word changed off an output edge");
  chk_oe_edge: assert property (
    $changed(rdDataOe) |-> $past(outEdge) || $past(outEdge, 2) || $past(outEdge, 3))
    else $error("drive enable changed off an output edge");
  chk_two_words: assert property (
    $rose(rdDataOe) |-> rdDataOe [*8]) else $error("burst shorter than two words");
  chk_read_cause: assert property (
    $rose(rdDataOe) |-> rdSeen_ff) else $error("output driven without a read");
  chk_hold_idle: assert property (
    !rdDataOe |-> $stable(rdDataOut)) else $error("read data moved while floating");
endmodule // sbs_burst_sram_asserts

bind sbs_burst_sram sbs_burst_sram_asserts sbs_burst_sram_asserts_i (.ref_clk, .rst_b,
  .kClk, .kClkN, .cClk, .cClkN, .dll_disable_n, .rd_port_sel_n, .rdDataOut, .rdDataOe,
  .dllEnabled, .singleClkMode);

// [sbs_ctl_model.sv]
// Behavioural memory controller driving clocks, selects, address and data
`timescale 1ns/100ps
module sbs_ctl_model (
  input  wire logic        refClk,          // Paces pin changes
  input  wire logic        strap,           // High: output clocks held high
  output logic             kClk,            // Input clock
  output logic             kClkN,           // Inverted input clock
  output logic             cClk,            // Output clock
  output logic             cClkN,           // Inverted output clock
  output logic             rd_port_sel_n,   // Read select
  output logic             wr_port_sel_n,   // Write select
  output logic      [1:0]  byte_lane_sel_n, // Lane selects
  output logic      [20:0] addrIn,          // Shared address
  output logic      [17:0] wrDataIn         // Write data
);
  // Free-running input clock, edges kept off system clock edges
  initial begin
    rd_port_sel_n   = 1'b1;
    wr_port_sel_n   = 1'b1;
    byte_lane_sel_n = 2'h3;
    addrIn          = '0;
    wrDataIn        = '0;
    kClk            = 1'b0;
    #13;
    forever #160 kClk = ~kClk;
  end
  assign kClkN = ~kClk;
  // Output clocks follow the input pair, or sit high as the strap
  assign cClk  = strap | kClk;
  assign cClkN = strap | kClkN;
  // One input clock cycle; pins move on the fourth refClk fall after each capture edge
  task automatic cycle(input logic rd, input logic wr, input logic [20:0] ra,
                       input logic [20:0] wa, input logic [17:0] d0, input logic [17:0] d1,
                       input logic [1:0] l0, input logic [1:0] l1);
    @(posedge kClkN);
    repeat (4) @(negedge refClk);
    rd_port_sel_n   = ~rd;
    wr_port_sel_n   = ~wr;
    addrIn          = ra;
    wrDataIn        = d0;
    byte_lane_sel_n = l0;
    @(posedge kClk);
    repeat (4) @(negedge refClk);
    rd_port_sel_n   = 1'b1;
    wr_port_sel_n   = 1'b1;
    addrIn          = wa;
    wrDataIn        = d1;
    byte_lane_sel_n = l1;
  endtask
endmodule // sbs_ctl_model

// [testbench.sv]
// Self-checking bench for the burst SRAM access logic
`timescale 1ns/100ps
module testbench;
  logic        ref_clk, rst_b, dll_disable_n, strap;    // Bench-driven pins
  logic        kClk, kClkN, cClk, cClkN;                // Clock pins
  logic        rd_port_sel_n, wr_port_sel_n;            // Port selects
  logic [1:0]  byte_lane_sel_n;                         // Lane selects
  logic [20:0] addrIn;                                  // Shared address
  logic [17:0] wrDataIn, rdDataOut;                     // Data pins
  logic        rdDataOe, dllEnabled, singleClkMode;     // Status outputs
  logic [17:0] expQ[$];                                 // Read words still due
  int          nErrors, nTests;                         // Verdict counters
  // System clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  sbs_burst_sram sbs_burst_sram_i (.ref_clk, .rst_b, .kClk, .kClkN, .cClk, .cClkN,
    .dll_disable_n, .rd_port_sel_n, .wr_port_sel_n, .byte_lane_sel_n, .addrIn, .wrDataIn,
    .rdDataOut, .rdDataOe, .dllEnabled, .singleClkMode);
  sbs_ctl_model sbs_ctl_model_i (.refClk(ref_clk), .strap, .kClk, .kClkN, .cClk, .cClkN,
    .rd_port_sel_n, .wr_port_sel_n, .byte_lane_sel_n, .addrIn, .wrDataIn);
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic close_out;
    if (nErrors == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with the chosen strap, outputs checked while held
  task automatic doReset(input logic s);
    strap = s;
    rst_b = 1'b0;
    repeat (20) @(negedge ref_clk);
    check("oe in reset", 0, rdDataOe);
    check("data in reset", 0, rdDataOut);
    rst_b = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("clock mode", s, singleClkMode);
  endtask
  // Words taken one output edge late; the model's C pair tracks K unless the strap holds it high
  task automatic readCheck(input int n);
    repeat (12) begin
      @(posedge kClk or posedge kClkN);
      if (rdDataOe === 1'b1) break;
    end
    if (rdDataOe !== 1'b1) begin
      check("read start", 1, rdDataOe);
      close_out;
    end
    repeat (n) begin
      check("read oe", 1, rdDataOe);
      check("read word", expQ.pop_front(), rdDataOut);
      @(posedge kClk or posedge kClkN);
    end
    check("float after burst", 0, rdDataOe);
  endtask
  // Write cycle, junk read address
  task automatic wr(input logic [20:0] a, input logic [17:0] d0, input logic [17:0] d1,
                    input logic [1:0] l0, input logic [1:0] l1);
    sbs_ctl_model_i.cycle(1'b0, 1'b1, ~a, a, d0, d1, l0, l1);
  endtask
  // Read cycle, junk write pins
  task automatic rd(input logic [20:0] a, input logic [17:0] e0, input logic [17:0] e1);
    expQ.push_back(e0);
    expQ.push_back(e1);
    fork
      sbs_ctl_model_i.cycle(1'b1, 1'b0, a, ~a, ~e0, ~e1, 2'h0, 2'h0);
      readCheck(2);
    join
  endtask
  // DLL status follows its pin both ways
  task automatic scenDll;
    dll_disable_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("dll off", 0, dllEnabled);
    dll_disable_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("dll on", 1, dllEnabled);
  endtask
  // Full write then read at the top address
  task automatic scenBasic;
    wr(21'h1fffff, 18'h3ffff, 18'h00001, 2'h0, 2'h0);
    rd(21'h1fffff, 18'h3ffff, 18'h00001);
  endtask
  // Every lane code on both words
  task automatic scenLanes;
    logic [1:0]  c;
    logic [17:0] m;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      m = {{9{c[1]}}, {9{c[0]}}};
      wr(21'h0abcde, 18'h2aaaa, 18'h2aaaa, 2'h0, 2'h0);
      wr(21'h0abcde, 18'h15555, 18'h15555, c, ~c);
      rd(21'h0abcde, (18'h2aaaa & m) | (18'h15555 & ~m),
         (18'h2aaaa & ~m) | (18'h15555 & m));
    end
  endtask
  // Back-to-back writes, then back-to-back reads with no gap
  task automatic scenBackToBack;
    wr(21'h000010, 18'h0a5a5, 18'h1c3c3, 2'h0, 2'h0);
    wr(21'h000000, 18'h01234, 18'h3fedc, 2'h0, 2'h0);
    expQ = {18'h0a5a5, 18'h1c3c3, 18'h01234, 18'h3fedc};
    fork
      begin
        sbs_ctl_model_i.cycle(1'b1, 1'b0, 21'h000010, '0, '0, '0, 2'h3, 2'h3);
        sbs_ctl_model_i.cycle(1'b1, 1'b0, 21'h000000, '0, '0, '0, 2'h3, 2'h3);
      end
      readCheck(4);
    join
  endtask
  // Read and write to one place in the same cycle
  task automatic scenConcurrent;
    wr(21'h000123, 18'h11111, 18'h22222, 2'h0, 2'h0);
    expQ = {18'h2eeee, 18'h1dddd};
    fork
      sbs_ctl_model_i.cycle(1'b1, 1'b1, 21'h000123, 21'h000123, 18'h2eeee, 18'h1dddd,
                            2'h0, 2'h0);
      readCheck(2);
    join
  endtask
  // Both selects high with live address and data
  task automatic scenNop;
    wr(21'h000777, 18'h13579, 18'h2468a, 2'h0, 2'h0);
    sbs_ctl_model_i.cycle(1'b0, 1'b0, 21'h000777, 21'h000777, '0, '0, 2'h0, 2'h0);
    rd(21'h000777, 18'h13579, 18'h2468a);
  endtask
  // Second reset with the strap, traffic timed by the input clocks
  task automatic scenSingle;
    doReset(1'b1);
    wr(21'h055555, 18'h2b2b2, 18'h0d0d0, 2'h0, 2'h0);
    rd(21'h055555, 18'h2b2b2, 18'h0d0d0);
  endtask
  // Main sequence
  initial begin
    nErrors       = 0;
    nTests        = 0;
    dll_disable_n = 1'b1;
    doReset(1'b0);
    scenDll;
    scenBasic;
    scenLanes;
    scenBackToBack;
    scenConcurrent;
    scenNop;
    scenSingle;
    close_out;
  end
endmodule // testbench
